// ---- rtl/spc_ctrl.sv ----
`timescale 1ns/10ps
`include "spc_map.svh"
// Stop-mode power sequencer
module spc_ctrl
    import spc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       i_clock,
    input  wire logic       i_rst_b,
    input  wire logic       i_ce,
    // CPU core
    input  wire logic       i_stop_exec,      // Halt instruction decoded, pulse
    input  wire logic       i_stop_disable,   // Stop-disable condition bit
    input  wire logic       i_irq_mask,       // Maskable interrupt mask bit
    input  wire logic       i_xmask_clr,      // Software clears NMI mask, pulse
    input  wire logic       i_xmask_ack,      // NMI acknowledged by core, pulse
    input  wire logic       i_startup_delay_select, // Long delay when high
    input  wire logic       i_expanded,       // Expanded bus mode
    input  wire logic       i_wait_instruction, // Core in wait state
    input  wire logic [7:0] i_addr_hi,        // Upper address byte
    input  wire logic       i_phase_clk,      // Running bus phase clock
    input  wire logic       i_addr_strobe,    // Running address strobe
    input  wire logic [7:0] i_port_data,      // Port level in normal running
    // Pins
    input  wire logic       i_nonmaskable_int_pin_b,
    input  wire logic       i_irq_pin_b,
    // Status to core
    output logic            o_clock_run,
    output logic            o_osc_en,
    output logic            o_stop_nop,
    output logic            o_resume_next,
    output logic            o_stack_nmi,
    output logic            o_reset_vector,
    output logic            o_xmask,
    output logic            o_halted,
    // Pin outputs
    output logic [7:0]      o_high_address_port,
    output logic            o_phase_clk,
    output logic            o_strobe_in_or_addr_strobe
);
    spc_state_type state_q;     // Sequencer state
    spc_action_type act_q;      // Action to take after recovery
    logic          nmi_s;       // Synchronised NMI request
    logic          irq_s;       // Synchronised IRQ request
    logic          rst_seen_q;  // First cycle after reset
    logic          dly_start;   // Start of stabilisation wait
    logic          dly_done;    // End of stabilisation wait
    logic          wake;        // Any wake source

    // Pin synchronisers, active-low pins inverted before sync
    logic nmi_raw;
    logic irq_raw;
    spc_sync u_sync_nmi (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_async (~i_nonmaskable_int_pin_b),
        .o_sync  (nmi_raw)
    );
    spc_sync u_sync_irq (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_async (~i_irq_pin_b),
        .o_sync  (irq_raw)
    );
    assign nmi_s = nmi_raw;
    assign irq_s = irq_raw;

    // Wake on NMI always, IRQ only when unmasked
    assign wake = nmi_s | (irq_s & ~i_irq_mask);

    // Start wait on leaving halt
    assign dly_start = (state_q == SPC_HALT) && wake;

    // Stabilisation counter
    spc_delay u_delay (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_ce    (i_ce),
        .i_start (dly_start),
        .i_long  (i_startup_delay_select),
        .o_done  (dly_done)
    );

    // Main sequencer
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= SPC_RUN;
            act_q   <= SPC_ACT_NONE;
        end else if (i_ce) begin
            case (state_q)
                SPC_RUN: begin
                    if (i_stop_exec && !i_stop_disable) begin
                        state_q <= SPC_HALT;
                    end
                end
                SPC_HALT: begin
                    if (wake) begin
                        state_q <= SPC_RECOVER;
                        // NMI with mask clear, or IRQ alone, selects stacking; masked NMI resumes
                        act_q   <= (nmi_s && !o_xmask) ? SPC_ACT_STACK
                                 : (nmi_s ? SPC_ACT_NEXT : SPC_ACT_STACK);
                    end
                end
                SPC_RECOVER: begin
                    if (dly_done) begin
                        state_q <= SPC_RESUME;
                    end
                end
                SPC_RESUME: begin
                    state_q <= SPC_RUN;
                    act_q   <= SPC_ACT_NONE;
                end
                default: begin
                    state_q <= SPC_RUN;
                end
            endcase
        end
    end

    // Clock and oscillator enables
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_clock_run <= 1'b1;
            o_osc_en    <= 1'b1;
            o_halted    <= 1'b0;
        end else if (i_ce) begin
            // All clocks and oscillator off while halted
            o_clock_run <= !((state_q == SPC_RUN && i_stop_exec && !i_stop_disable)
                            || (state_q == SPC_HALT && !wake)
                            || state_q == SPC_RECOVER);
            o_osc_en    <= !(state_q == SPC_RUN && i_stop_exec && !i_stop_disable)
                           && !(state_q == SPC_HALT && !wake);
            o_halted    <= (state_q == SPC_RUN && i_stop_exec && !i_stop_disable)
                           || (state_q == SPC_HALT && !wake);
        end
    end

    // Result pulses to core
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_stop_nop     <= 1'b0;
            o_resume_next  <= 1'b0;
            o_stack_nmi    <= 1'b0;
            o_reset_vector <= 1'b0;
            rst_seen_q     <= 1'b0;
        end else if (i_ce) begin
            o_stop_nop     <= (state_q == SPC_RUN) && i_stop_exec && i_stop_disable;
            o_resume_next  <= (state_q == SPC_RESUME) && (act_q == SPC_ACT_NEXT);
            o_stack_nmi    <= (state_q == SPC_RESUME) && (act_q == SPC_ACT_STACK);
            o_reset_vector <= !rst_seen_q;
            rst_seen_q     <= 1'b1;
        end
    end

    // NMI mask: hardware sets, software clears; set wins
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_xmask <= `SPC_XMASK_RST;
        end else if (i_ce) begin
            if (i_xmask_ack) begin
                o_xmask <= 1'b1;
            end else if (i_xmask_clr) begin
                o_xmask <= 1'b0;
            end
        end
    end

    // Pin behaviour in normal, wait and halted states
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_high_address_port        <= `SPC_HADDR_RST;
            o_phase_clk                <= 1'b0;
            o_strobe_in_or_addr_strobe <= 1'b0;
        end else if (i_ce) begin
            if (i_expanded) begin
                o_high_address_port <= i_addr_hi;
            end else if (state_q == SPC_RUN && !i_wait_instruction) begin
                o_high_address_port <= i_port_data;
            end  // Held otherwise
            // Entering halt lowers the strobes together with the clock gates
            if (state_q == SPC_RUN && !(i_stop_exec && !i_stop_disable)) begin
                o_phase_clk                <= i_phase_clk;
                o_strobe_in_or_addr_strobe <= i_expanded & i_addr_strobe;
            end else begin
                o_phase_clk                <= 1'b0;
                o_strobe_in_or_addr_strobe <= 1'b0;
            end
        end
    end
endmodule : spc_ctrl

// ---- rtl/spc_map.svh ----
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// Oscillator stabilisation counts, in clock cycles
`define SPC_LONG_DELAY   12'hFE0
`define SPC_SHORT_DELAY  12'h004
// Reset values
`define SPC_XMASK_RST    1'b1
`define SPC_SMASK_RST    1'b1
`define SPC_DLY_RST      1'b1
`define SPC_HADDR_RST    8'h00

`endif

// ---- rtl/spc_pkg.sv ----
package spc_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        SPC_RUN,
        SPC_HALT,
        SPC_RECOVER,
        SPC_RESUME
    } spc_state_type;

    // Action handed back to the CPU core after recovery
    typedef enum logic [1:0] {
        SPC_ACT_NONE,
        SPC_ACT_NEXT,
        SPC_ACT_STACK
    } spc_action_type;

endpackage : spc_pkg

// ---- rtl/spc_sync.sv ----
`timescale 1ns/10ps
// Two-stage synchroniser for one asynchronous level
module spc_sync (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    // Data
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_q;  // First stage, read only by second stage

    // Capture and settle the pin level
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : spc_sync

// ---- rtl/spc_delay.sv ----
`timescale 1ns/10ps
`include "spc_map.svh"
// Down counter for oscillator stabilisation
module spc_delay (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    input  wire logic i_ce,
    // Control
    input  wire logic i_start,
    input  wire logic i_long,
    output logic      o_done
);
    logic [11:0] cnt_q;  // Cycles left

    // Load on start, then count down to zero
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q  <= 12'h000;
            o_done <= 1'b0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            if (i_start) begin
                cnt_q <= i_long ? `SPC_LONG_DELAY : `SPC_SHORT_DELAY;
            end else if (cnt_q != 12'h000) begin
                cnt_q <= cnt_q - 12'h001;
                if (cnt_q == 12'h001) begin
                    o_done <= 1'b1;
                end
            end
        end
    end
endmodule : spc_delay

// ---- tb/spc_ctrl_props.sv ----
`timescale 1ns/10ps
// Port checker for the stop-mode sequencer
module spc_ctrl_props (
    // Clock, reset and inputs
    input wire logic i_clock, i_rst_b, i_stop_exec, i_stop_disable,
    input wire logic i_irq_mask, i_xmask_ack, i_startup_delay_select,
    input wire logic i_expanded, i_nonmaskable_int_pin_b, i_irq_pin_b,
    // Outputs
    input wire logic o_clock_run, o_osc_en, o_stop_nop, o_resume_next,
    input wire logic o_stack_nmi, o_xmask, o_halted, o_phase_clk,
    input wire logic [7:0] o_high_address_port
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    // No wake source visible at the pins
    wire logic quiet = i_nonmaskable_int_pin_b && (i_irq_pin_b || i_irq_mask);
    a_halt_entry: assert property ($rose(o_halted) |-> !i_stop_disable &&
        ($past(i_stop_exec) || $past(i_stop_exec, 2))) else $error("halt without stop");
    a_nop_cause: assert property (o_stop_nop |-> i_stop_disable &&
        ($past(i_stop_exec) || $past(i_stop_exec, 2))) else $error("stray nop pulse");
    a_halt_gated: assert property (o_halted |-> !o_clock_run && !o_osc_en
        && !o_phase_clk) else $error("clocks run while halted");
    a_halt_holds: assert property (o_halted && quiet && $past(quiet) &&
        $past(quiet, 2) && $past(quiet, 3) |=> o_halted) else $error("wake without source");
    a_nmi_wakes: assert property (o_halted && !i_nonmaskable_int_pin_b
        |-> ##[0:4] !o_halted) else $error("nmi pin did not wake");
    a_short_delay: assert property ($fell(o_halted) && !i_startup_delay_select
        |-> ##[2:12] (o_stack_nmi || o_resume_next)) else $error("short wait wrong");
    a_xmask_source: assert property ($rose(o_xmask) |-> $past(i_xmask_ack))
        else $error("nmi mask set without ack");
    a_resume_masked: assert property (o_resume_next |-> o_xmask)
        else $error("resume with nmi mask clear");
    a_port_steady: assert property (o_halted && $past(o_halted) && !i_expanded
        |-> $stable(o_high_address_port)) else $error("port moved while halted");
    c_halt: cover property ($rose(o_halted));
    c_resume: cover property (o_resume_next);
    c_stack: cover property (o_stack_nmi);
endmodule : spc_ctrl_props

bind spc_ctrl spc_ctrl_props props (.i_clock, .i_rst_b, .i_stop_exec, .i_stop_disable,
    .i_irq_mask, .i_xmask_ack, .i_startup_delay_select, .i_expanded,
    .i_nonmaskable_int_pin_b, .i_irq_pin_b, .o_clock_run, .o_osc_en, .o_stop_nop,
    .o_resume_next, .o_stack_nmi, .o_xmask, .o_halted, .o_phase_clk, .o_high_address_port);

// ---- tb/spc_pins_model.sv ----
`timescale 1ns/10ps
// Board-side interrupt pins, pulled high while nobody requests
module spc_pins_model (
    input  wire logic i_clock,
    input  wire logic i_nmi_req,
    input  wire logic i_irq_req,
    output logic      o_nmi_pin_b = 1'b1,
    output logic      o_irq_pin_b = 1'b1
);
    // Pins move after the falling edge, low while requested
    always @(negedge i_clock) begin
        o_nmi_pin_b <= ~i_nmi_req;
        o_irq_pin_b <= ~i_irq_req;
    end
endmodule : spc_pins_model

// ---- tb/stop_mode_power_control_test.sv ----
`timescale 1ns/10ps
module stop_mode_power_control_test;
    // Design side signals
    logic i_clock, i_rst_b, i_ce, i_stop_exec, i_stop_disable, i_irq_mask, nmi, irq;
    logic i_xmask_clr, i_xmask_ack, i_startup_delay_select, i_expanded, i_phase_clk;
    logic i_wait_instruction, i_addr_strobe, i_nonmaskable_int_pin_b, i_irq_pin_b;
    logic o_clock_run, o_osc_en, o_stop_nop, o_resume_next, o_stack_nmi, o_phase_clk;
    logic o_reset_vector, o_xmask, o_halted, o_strobe_in_or_addr_strobe;
    logic [7:0] i_addr_hi, i_port_data, o_high_address_port, keep;
    int failures, checked, n, nops, vecs;
    spc_ctrl dut (.i_clock, .i_rst_b, .i_ce, .i_stop_exec, .i_stop_disable, .i_irq_mask,
        .i_xmask_clr, .i_xmask_ack, .i_startup_delay_select, .i_expanded,
        .i_wait_instruction, .i_addr_hi, .i_phase_clk, .i_addr_strobe, .i_port_data,
        .i_nonmaskable_int_pin_b, .i_irq_pin_b, .o_clock_run, .o_osc_en, .o_stop_nop,
        .o_resume_next, .o_stack_nmi, .o_reset_vector, .o_xmask, .o_halted,
        .o_high_address_port, .o_phase_clk, .o_strobe_in_or_addr_strobe);
    spc_pins_model pins (.i_clock, .i_nmi_req(nmi), .i_irq_req(irq),
        .o_nmi_pin_b(i_nonmaskable_int_pin_b), .o_irq_pin_b(i_irq_pin_b));
    // Tally of one-cycle pulses
    always @(posedge i_clock) begin
        nops <= nops + int'(o_stop_nop === 1'b1);
        vecs <= vecs + int'(o_reset_vector === 1'b1);
    end
    // Verdict and end of run
    task automatic results();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    // Compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Falling edges, where inputs change
    task automatic tick(input int k);
        repeat (k) @(negedge i_clock);
    endtask : tick
    // One halt instruction, then two more falling edges for the halted state to settle
    task automatic stop();
        i_stop_exec = 1'b1;
        tick(1);
        i_stop_exec = 1'b0;
        tick(2);
    endtask : stop
    // Bounded wait for the halted state to end, then for the result pulse
    task automatic wake();
        n = 0;
        while (o_halted === 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        if (n >= 40) begin
            failures++;
            results();
        end
        n = 0;
        while (!(o_stack_nmi === 1'b1 || o_resume_next === 1'b1) && n < 5000) begin
            @(posedge i_clock);
            #1 n++;
        end
        if (n >= 5000) begin
            failures++;
            results();
        end
    endtask : wake
    // Halt disabled behaves as a plain step
    task automatic t_nop();
        i_stop_disable = 1'b1;
        nops = 0;
        stop();
        chk("nop pulses", 8'h01, 8'(nops));
        chk("halted", 8'h00, {7'h0, o_halted});
        i_stop_disable = 1'b0;
        $display("test nop finished");
    endtask : t_nop
    // Halt, wake on the nmi pin, check the recovery path and the mask
    task automatic t_nmi(input logic masked, input logic long);
        i_xmask_clr = !masked;
        tick(1);
        i_xmask_clr = 1'b0;
        i_startup_delay_select = long;
        keep = o_high_address_port;
        stop();
        chk("halt state", 8'h08, {4'h0, o_halted, o_clock_run, o_osc_en, o_phase_clk});
        i_port_data = ~i_port_data;
        tick(5);
        chk("held port", keep, o_high_address_port);
        nmi = 1'b1;
        wake();
        chk("path", masked ? 8'h01 : 8'h02, {6'h0, o_stack_nmi, o_resume_next});
        chk("delay ok", 8'h01, 8'(long ? (n >= 4062 && n <= 4074) : (n >= 2 && n <= 10)));
        tick(1);
        nmi = 1'b0;
        i_xmask_ack = 1'b1;
        tick(1);
        i_xmask_ack = 1'b0;
        tick(1);
        chk("mask after ack", 8'h01, {7'h0, o_xmask});
        $display("test nmi finished");
    endtask : t_nmi
    // Masked irq leaves the device halted; unmasking wakes it
    task automatic t_irq();
        i_irq_mask = 1'b1;
        irq = 1'b1;
        stop();
        tick(20);
        chk("still halted", 8'h01, {7'h0, o_halted});
        i_irq_mask = 1'b0;
        wake();
        chk("irq path", 8'h02, {6'h0, o_stack_nmi, o_resume_next});
        irq = 1'b0;
        tick(3);
        $display("test irq finished");
    endtask : t_irq
    // Expanded halt shows the address, then reset ends it
    task automatic t_rst();
        i_expanded = 1'b1;
        stop();
        chk("high address", 8'hA5, o_high_address_port);
        chk("strobe", 8'h00, {7'h0, o_strobe_in_or_addr_strobe});
        i_rst_b = 1'b0;
        tick(2);
        vecs = 0;
        i_rst_b = 1'b1;
        tick(3);
        chk("vector pulses", 8'h01, 8'(vecs));
        chk("run after reset", 8'h01, {6'h0, o_halted, o_xmask});
        $display("test reset finished");
    endtask : t_rst
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    initial begin
        {i_rst_b, i_stop_exec, i_stop_disable, i_irq_mask, nmi, irq} = '0;
        {i_xmask_clr, i_xmask_ack, i_expanded, i_wait_instruction} = '0;
        {i_ce, i_phase_clk, i_addr_strobe, i_startup_delay_select} = '1;
        i_addr_hi = 8'hA5;
        i_port_data = 8'h3C;
        tick(6);
        i_rst_b = 1'b1;
        tick(2);
        t_nop();
        t_nmi(1'b1, 1'b0);
        t_nmi(1'b0, 1'b0);
        t_irq();
        t_nmi(1'b1, 1'b1);
        t_rst();
        results();
    end
endmodule : stop_mode_power_control_test
